// ### core/mclo_top.sv
`timescale 1ns/100ps
`default_nettype none


module mclo_top
    import mclo_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Mode and line inputs
    input  wire logic        hw_mode,
    input  wire logic        mclk_in,
    input  wire logic        rx_pulse_in,
    // Shared pin and interrupt
    output logic             rx_signal_loss_out1,
    output logic             irq
);

    typedef struct packed {
        logic [31:0]          prdata;
        logic                 pready;
        logic                 pslverr;
        logic [MC_WIDTH-1:0]  mcfg;
        logic [CC_WIDTH-1:0]  ccfg;
        logic [IRQ_WIDTH-1:0] ists;
        logic [IRQ_WIDTH-1:0] imask;
        logic                 mclk_d;
        logic [2:0]           pre_cnt;
        logic [9:0]           acc;
        logic                 e1_ph;
        logic                 t1_ph;
        logic                 los_d;
        logic                 pin;
        logic                 irq;
    } mclo_state_s;

    localparam mclo_state_s STATE_RESET = '{
        prdata:  32'h0000_0000,
        pready:  1'b0,
        pslverr: 1'b0,
        mcfg:    MC_RESET,
        ccfg:    CC_RESET,
        ists:    IRQ_RESET,
        imask:   IRQ_RESET,
        mclk_d:  1'b0,
        pre_cnt: 3'h0,
        acc:     10'h000,
        e1_ph:   1'b0,
        t1_ph:   1'b0,
        los_d:   1'b0,
        pin:     1'b0,
        irq:     1'b0
    };

    // Last count of the half-period prescaler: divide by 1, 2, 4 or 8
    function automatic logic [2:0] prescale_last(input logic [1:0] sel);
        unique case (sel)
            2'b00: prescale_last = 3'h0;
            2'b01: prescale_last = 3'h1;
            2'b10: prescale_last = 3'h3;
            2'b11: prescale_last = 3'h7;
        endcase
    endfunction

    // Address decode shared by the read mux and the error answer
    function automatic logic reg_mapped(input logic [7:0] a);
        unique case (a)
            OFS_MASTER_CFG: reg_mapped = 1'b1;
            OFS_CLOCK_CFG:  reg_mapped = 1'b1;
            OFS_STATUS:     reg_mapped = 1'b1;
            OFS_INT_STS:    reg_mapped = 1'b1;
            OFS_INT_MASK:   reg_mapped = 1'b1;
            default:        reg_mapped = 1'b0;
        endcase
    endfunction

    logic        rst_meta_r;
    logic        rst_sync_r;
    mclo_state_s s_r;
    mclo_state_s s_nxt;
    logic        los;
    logic        bit_tick;
    logic [1:0]  los_method;

    // Reset release through two flops; the assertion stays asynchronous
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // ETSI criteria are not offered without software control
    always_comb begin
        los_method = s_r.ccfg[CC_LOS_MSB:CC_LOS_LSB];
        if (hw_mode && los_method == LOS_ETSI) begin
            los_method = LOS_T1231;
        end
    end

    mclo_los_det u_los_det (
        .clk      (clk),
        .rst_n    (rst_sync_r),
        .bit_tick (bit_tick),
        .rx_mark  (rx_pulse_in),
        .method   (los_method),
        .los      (los)
    );

    always_comb begin
        logic        mclk_edge;
        logic        native_tick;
        logic        native_e1;
        logic        adapt;
        logic        other_tick;
        logic        e1_half;
        logic        t1_half;
        logic        line_half;
        logic        line_ph;
        logic        ref_en;
        logic        ev_set;
        logic        ev_clr;
        logic [2:0]  last;
        logic [9:0]  num;
        logic [9:0]  den;
        logic [9:0]  sum;
        logic        acc_wr;
        logic        rd_hit;
        logic [31:0] rd_data;
        logic [IRQ_WIDTH-1:0] w1c;
        logic [IRQ_WIDTH-1:0] ev;

        s_nxt       = s_r;
        native_tick = 1'b0;
        other_tick  = 1'b0;
        w1c         = '0;
        rd_hit      = reg_mapped(paddr);
        rd_data     = 32'h0000_0000;

        mclk_edge   = 1'b0;
        native_e1   = 1'b0;
        adapt       = 1'b0;
        e1_half     = 1'b0;
        t1_half     = 1'b0;
        line_half   = 1'b0;
        line_ph     = 1'b0;
        ref_en      = 1'b0;
        ev_set      = 1'b0;
        ev_clr      = 1'b0;
        last        = 3'h0;
        num         = 10'h000;
        den         = 10'h000;
        sum         = 10'h000;
        acc_wr      = 1'b0;
        ev          = '0;
        bit_tick    = 1'b0;

        // The oscillator is assumed free-running, so both edges keep arriving
        // Each mclk level must span a clk edge; a faster oscillator loses edges
        mclk_edge    = mclk_in ^ s_r.mclk_d;
        s_nxt.mclk_d = mclk_in;

        // Hardware mode ignores the prescaler and the synthesizer
        if (hw_mode) begin
            last = 3'h0;
        end else begin
            last = prescale_last(s_r.mcfg[MC_PRESCALE_SEL1:MC_PRESCALE_SEL0]);
        end
        if (mclk_edge) begin
            if (s_r.pre_cnt >= last) begin
                s_nxt.pre_cnt = 3'h0;
                native_tick   = 1'b1;
            end else begin
                s_nxt.pre_cnt = s_r.pre_cnt + 3'h1;
            end
        end

        // With the synthesizer on, the oscillator belongs to the other family
        adapt     = s_r.mcfg[MC_SYNTH_EN] & ~hw_mode;
        native_e1 = s_r.mcfg[MC_BASE_RATE] ^ adapt;

        // Fractional rate change 193/256 or 256/193; at most one tick per clock
        // Ten bits suffice: the residue plus one step never reaches 512
        num = native_e1 ? RATE_T1_NUM : RATE_E1_NUM;
        den = native_e1 ? RATE_E1_NUM : RATE_T1_NUM;
        sum = s_r.acc + (native_tick ? num : 10'h000);
        acc_wr = 1'b0;
        if (sum >= den) begin
            sum    = sum - den;
            acc_wr = 1'b1;
        end
        other_tick = acc_wr & adapt;
        s_nxt.acc  = adapt ? sum : 10'h000;

        e1_half = native_e1 ? native_tick : other_tick;
        t1_half = native_e1 ? other_tick : native_tick;
        s_nxt.e1_ph = s_r.e1_ph ^ e1_half;
        s_nxt.t1_ph = s_r.t1_ph ^ t1_half;

        // One received bit per full period of the line rate
        line_half = s_r.mcfg[MC_BASE_RATE] ? e1_half : t1_half;
        line_ph   = s_r.mcfg[MC_BASE_RATE] ? s_r.e1_ph : s_r.t1_ph;
        bit_tick  = line_half & line_ph;

        // Shared pin selection
        // Registered, so the pin cannot glitch when its function changes
        ref_en = s_r.mcfg[MC_REF_CLK_EN] & ~hw_mode;
        if (ref_en) begin
            s_nxt.pin = s_r.ccfg[CC_REF_RATE_E1] ? s_r.e1_ph : s_r.t1_ph;
        end else begin
            s_nxt.pin = los;
        end

        // Loss events
        ev_set      = los & ~s_r.los_d;
        ev_clr      = ~los & s_r.los_d;
        s_nxt.los_d = los;
        ev          = '0;
        ev[IRQ_LOS_SET] = ev_set;
        ev[IRQ_LOS_CLR] = ev_clr;

        // APB: pready rises in the second access cycle
        s_nxt.pready  = 1'b0;
        s_nxt.pslverr = 1'b0;
        unique case (paddr)
            OFS_MASTER_CFG: rd_data[MC_WIDTH-1:0]  = s_r.mcfg;
            OFS_CLOCK_CFG:  rd_data[CC_WIDTH-1:0]  = s_r.ccfg;
            OFS_STATUS: begin
                rd_data[ST_HW_MODE]   = hw_mode;
                rd_data[ST_LOS]       = los;
                rd_data[ST_NATIVE_E1] = native_e1;
                rd_data[ST_ADAPT]     = adapt;
            end
            OFS_INT_STS:    rd_data[IRQ_WIDTH-1:0] = s_r.ists;
            OFS_INT_MASK:   rd_data[IRQ_WIDTH-1:0] = s_r.imask;
            default:        rd_data = 32'h0000_0000;
        endcase
        // Writes and refused accesses answer with zero data
        if (psel && penable && !s_r.pready) begin
            s_nxt.pready  = 1'b1;
            s_nxt.pslverr = ~rd_hit;
            s_nxt.prdata  = (!pwrite && rd_hit) ? rd_data : 32'h0000_0000;
        end
        if (psel && penable && s_r.pready && pwrite && rd_hit) begin
            unique case (paddr)
                OFS_MASTER_CFG: s_nxt.mcfg  = pwdata[MC_WIDTH-1:0];
                OFS_CLOCK_CFG:  s_nxt.ccfg  = pwdata[CC_WIDTH-1:0];
                OFS_INT_STS:    w1c         = pwdata[IRQ_WIDTH-1:0];
                OFS_INT_MASK:   s_nxt.imask = pwdata[IRQ_WIDTH-1:0];
                default:        s_nxt.mcfg  = s_r.mcfg;
            endcase
        end

        // A new event in the clearing cycle survives
        s_nxt.ists = (s_r.ists & ~w1c) | ev;
        s_nxt.irq  = |(s_nxt.ists & s_nxt.imask);
    end

    always_ff @(posedge clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            s_r <= STATE_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata              = s_r.prdata;
    assign pready              = s_r.pready;
    assign pslverr             = s_r.pslverr;
    assign rx_signal_loss_out1 = s_r.pin;
    assign irq                 = s_r.irq;

endmodule

`default_nettype wire

// ### core/mclo_pkg.sv
package mclo_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_MASTER_CFG = 8'h00;
    localparam logic [7:0] OFS_CLOCK_CFG  = 8'h04;
    localparam logic [7:0] OFS_STATUS     = 8'h08;
    localparam logic [7:0] OFS_INT_STS    = 8'h0c;
    localparam logic [7:0] OFS_INT_MASK   = 8'h10;

    // master_config_reg fields
    localparam int MC_PRESCALE_SEL0 = 0;
    localparam int MC_PRESCALE_SEL1 = 1;
    localparam int MC_BASE_RATE     = 2;
    localparam int MC_SYNTH_EN      = 3;
    localparam int MC_REF_CLK_EN    = 4;
    localparam int MC_WIDTH         = 5;
    localparam logic [4:0] MC_RESET = 5'h00;

    // clock_config_reg fields
    localparam int CC_REF_RATE_E1 = 0;
    localparam int CC_LOS_LSB     = 1;
    localparam int CC_LOS_MSB     = 2;
    localparam int CC_WIDTH       = 3;
    localparam logic [2:0] CC_RESET = 3'h0;

    // Status register fields
    localparam int ST_HW_MODE   = 0;
    localparam int ST_LOS       = 1;
    localparam int ST_NATIVE_E1 = 2;
    localparam int ST_ADAPT     = 3;

    // Interrupt status and mask fields
    localparam int IRQ_LOS_SET = 0;
    localparam int IRQ_LOS_CLR = 1;
    localparam int IRQ_WIDTH   = 2;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    // 2.048 / 1.544 reduces to 256 / 193
    localparam logic [9:0] RATE_E1_NUM = 10'h100;
    localparam logic [9:0] RATE_T1_NUM = 10'h0c1;

    // Loss criteria, counted in received bit periods
    typedef enum logic [1:0] {
        LOS_T1231 = 2'b00,
        LOS_G775  = 2'b01,
        LOS_ETSI  = 2'b11
    } mclo_los_method_e;

    localparam logic [11:0] T1231_ZEROS = 12'h0af;
    localparam logic [11:0] T1231_WIN   = 12'h0af;
    localparam logic [11:0] T1231_ONES  = 12'h016;
    localparam logic [11:0] G775_ZEROS  = 12'h020;
    localparam logic [11:0] G775_WIN    = 12'h020;
    localparam logic [11:0] G775_ONES   = 12'h004;
    localparam logic [11:0] ETSI_ZEROS  = 12'h800;
    localparam logic [11:0] ETSI_WIN    = 12'h800;
    localparam logic [11:0] ETSI_ONES   = 12'h100;

    // Code 2'b10 is illegal and falls back to the first method
    function automatic logic [11:0] los_zeros(input logic [1:0] m);
        unique case (m)
            LOS_G775: los_zeros = G775_ZEROS;
            LOS_ETSI: los_zeros = ETSI_ZEROS;
            default:  los_zeros = T1231_ZEROS;
        endcase
    endfunction

    function automatic logic [11:0] los_win(input logic [1:0] m);
        unique case (m)
            LOS_G775: los_win = G775_WIN;
            LOS_ETSI: los_win = ETSI_WIN;
            default:  los_win = T1231_WIN;
        endcase
    endfunction

    function automatic logic [11:0] los_ones(input logic [1:0] m);
        unique case (m)
            LOS_G775: los_ones = G775_ONES;
            LOS_ETSI: los_ones = ETSI_ONES;
            default:  los_ones = T1231_ONES;
        endcase
    endfunction

endpackage

// ### core/mclo_los_det.sv
`timescale 1ns/100ps
`default_nettype none

module mclo_los_det
    import mclo_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Received bits
    input  wire logic       bit_tick,
    input  wire logic       rx_mark,
    input  wire logic [1:0] method,
    // Indication
    output logic            los
);

    typedef enum logic {
        LD_CLEAR = 1'b0,
        LD_LOST  = 1'b1
    } mclo_ld_e;

    typedef struct packed {
        mclo_ld_e    st;
        logic [11:0] zeros;
        logic [11:0] win;
        logic [11:0] ones;
    } mclo_ld_s;

    mclo_ld_s s_r;
    mclo_ld_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (bit_tick) begin
            unique case (s_r.st)
                LD_CLEAR: begin
                    if (rx_mark) begin
                        s_nxt.zeros = 12'h000;
                    end else if (s_r.zeros + 12'h001 >= los_zeros(method)) begin
                        s_nxt.st    = LD_LOST;
                        s_nxt.zeros = 12'h000;
                        s_nxt.win   = 12'h000;
                        s_nxt.ones  = 12'h000;
                    end else begin
                        s_nxt.zeros = s_r.zeros + 12'h001;
                    end
                end
                LD_LOST: begin
                    s_nxt.ones = s_r.ones + {11'h000, rx_mark};
                    s_nxt.win  = s_r.win + 12'h001;
                    // Density is judged per whole window, so recovery waits one window
                    if (s_nxt.win >= los_win(method)) begin
                        if (s_nxt.ones >= los_ones(method)) begin
                            s_nxt.st = LD_CLEAR;
                        end
                        s_nxt.win  = 12'h000;
                        s_nxt.ones = 12'h000;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '{st: LD_CLEAR, zeros: 12'h000, win: 12'h000, ones: 12'h000};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign los = (s_r.st == LD_LOST);

endmodule

`default_nettype wire

// ### verification/mclo_top_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module mclo_top_monitor (
    // Clock, reset and APB
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Mode, line and shared pin
    input wire logic        hw_mode,
    input wire logic        mclk_in,
    input wire logic        rx_pulse_in,
    input wire logic        rx_signal_loss_out1,
    input wire logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wire logic acc = psel && penable && !pready;

    property p_answer; acc |=> pready; endproperty
    a_answer: assert property (p_answer) else $error("no answer after access");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
    property p_idle; !(psel && penable) |=> !pready; endproperty
    a_idle: assert property (p_idle) else $error("pready without access");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("pslverr without pready");
    property p_unmapped; acc && paddr > 8'h10 |=> pslverr && prdata == 32'h0000_0000; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped address not refused");
    property p_mapped; acc && paddr[1:0] == 2'h0 && paddr <= 8'h10 |=> !pslverr; endproperty
    a_mapped: assert property (p_mapped) else $error("mapped address refused");
    property p_wr_zero; pready && pwrite |-> prdata == 32'h0000_0000; endproperty
    a_wr_zero: assert property (p_wr_zero) else $error("read data on write");
    property p_mask_off;
        pready && pwrite && paddr == 8'h10 && pwdata[1:0] == 2'h0 |-> ##3 !irq;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("irq with mask cleared");
    property p_hw_pin;
        hw_mode [*4] ##0 $changed(rx_signal_loss_out1)
            |=> (!hw_mode || $stable(rx_signal_loss_out1)) [*8];
    endproperty
    a_hw_pin: assert property (p_hw_pin) else $error("pin toggles in hw mode");
    property p_reset_pin; $rose(rstn) |-> !rx_signal_loss_out1 [*3]; endproperty
    a_reset_pin: assert property (p_reset_pin) else $error("pin high after reset");

    c_err: cover property (pslverr);
    c_loss: cover property ($rose(rx_signal_loss_out1));
    c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

// ### verification/mclo_osc.sv
`timescale 1ns/100ps
`default_nettype none
module mclo_osc #(
    parameter realtime HALF_NS = 20.3
) (
    output logic mclk
);
    // Free-running, twelve times the E1 base rate, phase unrelated to clk
    initial begin
        mclk = 1'b0;
        #1.3;
        // Non-blocking, so a change that meets a clk edge is seen after it
        forever #(HALF_NS) mclk <= ~mclk;
    end
endmodule
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench
    import mclo_pkg::*;
;
    logic        clk, rstn, psel, penable, pwrite, hw_mode, rx_pulse_in;
    logic        pready, pslverr, pin, irq, mclk, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    int          failures, cmp_count, c1, c2;

    mclo_top mclo_top_inst (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hw_mode(hw_mode), .mclk_in(mclk), .rx_pulse_in(rx_pulse_in),
        .rx_signal_loss_out1(pin), .irq(irq));
    mclo_osc mclo_osc_inst (.mclk(mclk));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Entered just after a rising edge; one idle edge follows each transfer
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // No limit here: a slave that never answers is caught by the watchdog
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clk);
    endtask

    // Skips the pin's output latency before counting changes
    task automatic toggles(output int c);
        logic p;
        c = 0;
        repeat (4) @(posedge clk);
        p = pin;
        repeat (400) begin
            @(posedge clk);
            if (pin !== p) c++;
            p = pin;
        end
    endtask

    task automatic wait_pin(input logic v, input int lim);
        int n;
        n = 0;
        while (pin !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
        check(pin, v);
    endtask

    task automatic t_reset();
        apb(0, OFS_MASTER_CFG, 0); check(rd, 32'h0000_0000);
        apb(0, OFS_CLOCK_CFG, 0); check(rd, 32'h0000_0000);
        check(pin, 0);
        apb(0, 8'h40, 0); check(er, 1);
        check(rd, 32'h0000_0000);
        apb(1, OFS_STATUS, 32'hffff_ffff); check(er, 0);
        apb(0, OFS_STATUS, 0); check(rd[0], 0);
        $display("t_reset done");
    endtask

    task automatic t_loss();
        apb(1, OFS_CLOCK_CFG, 32'h0000_0002);
        rx_pulse_in <= 1'b0;
        wait_pin(1, 4000);
        apb(0, OFS_STATUS, 0); check(rd[1], 1);
        apb(0, OFS_INT_STS, 0); check(rd[1:0], 2'b01);
        apb(1, OFS_INT_MASK, 32'h0000_0003);
        repeat (3) @(posedge clk);
        check(irq, 1);
        apb(1, OFS_INT_STS, 32'h0000_0001);
        repeat (3) @(posedge clk);
        check(irq, 0);
        rx_pulse_in <= 1'b1;
        wait_pin(0, 4000);
        apb(0, OFS_INT_STS, 0); check(rd[1:0], 2'b10);
        apb(1, OFS_INT_MASK, 0);
        apb(1, OFS_INT_STS, 32'h0000_0003);
        $display("t_loss done");
    endtask

    task automatic t_ref();
        apb(1, OFS_MASTER_CFG, 32'h0000_0014);
        apb(1, OFS_CLOCK_CFG, 32'h0000_0001);
        toggles(c1); check(c1 >= 97 && c1 <= 100, 1);
        // Prescale code 3: one half period per eight oscillator edges
        apb(1, OFS_MASTER_CFG, 32'h0000_0017);
        toggles(c2); check(c2 >= 11 && c2 <= 14, 1);
        apb(1, OFS_CLOCK_CFG, 0);
        toggles(c2); check(c2, 0);
        apb(1, OFS_MASTER_CFG, 32'h0000_001c);
        apb(0, OFS_STATUS, 0); check(rd[3:2], 2'b10);
        toggles(c2); check(c2 != 0, 1);
        apb(1, OFS_CLOCK_CFG, 32'h0000_0001);
        toggles(c1); check(c1 > c2 + 25, 1);
        $display("t_ref done");
    endtask

    task automatic t_hw();
        // Software mode keeps the long third method: no loss after 2000 cycles
        apb(1, OFS_CLOCK_CFG, 32'h0000_0006);
        rx_pulse_in <= 1'b0;
        repeat (2000) @(posedge clk);
        apb(0, OFS_STATUS, 0); check(rd[1], 0);
        rx_pulse_in <= 1'b1;
        hw_mode <= 1'b1;
        apb(0, OFS_STATUS, 0); check(rd[3:0], 4'b0101);
        toggles(c1); check(c1, 0);
        // Third method code must fall back to the first under hardware mode
        apb(1, OFS_CLOCK_CFG, 32'h0000_0006);
        rx_pulse_in <= 1'b0;
        wait_pin(1, 8000);
        rx_pulse_in <= 1'b1;
        wait_pin(0, 8000);
        hw_mode <= 1'b0;
        $display("t_hw done");
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        failures++;
        give_verdict();
    end

    initial begin
        failures = 0; cmp_count = 0; rstn = 1'b0; psel = 1'b0; penable = 1'b0;
        pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0000_0000;
        hw_mode = 1'b0; rx_pulse_in = 1'b1;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_loss();
        t_ref();
        t_hw();
        give_verdict();
    end
endmodule

bind mclo_top mclo_top_monitor mclo_top_monitor_inst (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hw_mode(hw_mode), .mclk_in(mclk_in),
    .rx_pulse_in(rx_pulse_in), .rx_signal_loss_out1(rx_signal_loss_out1), .irq(irq));
`default_nettype wire
